// [rtl/arf_top.sv]
// arf_top.sv: converter result queue with a clear-on-read readout register,
// reached over apb, with sticky event status and a level interrupt.
// assumes the converter core pulses conv_valid once per finished result,
// and that pen_down is already a clean level in the pclk domain.
//
// The address map and register access over APB were decided locally.
`timescale 1ns/1ps
`include "arf_cfg.svh"

module arf_top
	import arf_pkg::*;
#(
	parameter int DEPTH = `ARF_QUEUE_DEPTH,
	parameter int RES_W = `ARF_RES_W
)
(
	input  wire logic                   pclk,
	input  wire logic                   presetn,
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [`ARF_ADDR_W-1:0] paddr,
	input  wire logic [31:0]            pwdata,
	input  wire logic [3:0]             pstrb,
	output logic      [31:0]            prdata,
	output logic                        pready,
	output logic                        pslverr,
	input  wire logic                   conv_valid,
	input  wire logic [RES_W-1:0]       conv_data,
	input  wire logic                   conv_sign,
	input  wire logic                   pen_down,
	output logic                        irq
);

	// the display register is one of the entries; the rest sit behind it
	localparam int BACK  = DEPTH - 1;
	localparam int ENT_W = RES_W + 1;
	localparam int LVL_W = $clog2(BACK + 1);
	localparam int OCC_W = $clog2(DEPTH + 1);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	arf_apb_st_t               st_q;
	arf_apb_st_t               st_d;
	logic [31:0]               rdata_q;
	logic                      err_q;
	logic                      rd_done_q;
	logic                      rd_oflw_q;
	logic [RES_W-1:0]          res_q;
	logic                      sign_q;
	logic                      done_q;
	logic                      oflw_q;
	logic [`ARF_STS_W-1:0]     sts_q;
	logic [`ARF_STS_W-1:0]     mask_q;
	logic                      diff_q;

	logic                      back_ready;
	logic                      back_valid;
	logic [ENT_W-1:0]          back_data;
	logic [LVL_W-1:0]          back_level;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// match the bus address against one register offset
	function automatic logic hit(input logic [`ARF_ADDR_W-1:0] a,
		input logic [`ARF_ADDR_W-1:0] ofs);
		hit = (a == ofs);
	endfunction

	// place a status-wide flag field in the low bits of a bus word
	function automatic logic [31:0] flag_word(input logic [`ARF_STS_W-1:0] f);
		flag_word = {{(32-`ARF_STS_W){1'b0}}, f};
	endfunction

	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------
	wire sel_res  = hit(paddr, `ARF_OFS_RESULT);
	wire sel_sts  = hit(paddr, `ARF_OFS_STATUS);
	wire sel_mask = hit(paddr, `ARF_OFS_MASK);
	wire sel_cfg  = hit(paddr, `ARF_OFS_CONFIG);
	wire sel_lvl  = hit(paddr, `ARF_OFS_LEVEL);
	wire mapped   = sel_res | sel_sts | sel_mask | sel_cfg | sel_lvl;

	// ----------------------------------------------------------------
	// apb phase control
	// ----------------------------------------------------------------
	wire access   = psel & penable;
	wire complete = access & (st_q == ARF_ANSWER);
	wire capture  = access & (st_q == ARF_CAPTURE);
	wire wr_ok    = complete & pwrite & mapped & pstrb[0];
	wire rd_res   = complete & ~pwrite & sel_res;

	always_comb
	begin
		st_d = st_q;
		case (st_q)
			ARF_IDLE:
				if (psel & ~penable)
					st_d = ARF_CAPTURE;
			ARF_CAPTURE:
				if (access)
					st_d = ARF_ANSWER;
				else if (~psel)
					st_d = ARF_IDLE;
			ARF_ANSWER:
				st_d = ARF_IDLE;
			default:
				st_d = ARF_IDLE;
		endcase
	end

	assign pready  = (st_q == ARF_ANSWER);
	assign pslverr = pready & err_q;
	assign prdata  = rdata_q;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			st_q <= ARF_IDLE;
		else
			st_q <= st_d;
	end

	// ----------------------------------------------------------------
	// readout word as software sees it
	// ----------------------------------------------------------------
	wire [RES_W-1:0] res_shown  = done_q ? res_q : '0;
	wire             sign_shown = done_q & diff_q & sign_q;

	wire [15:0] result_word =
	{
		done_q,
		oflw_q,
		pen_down,
		sign_shown,
		res_shown
	};

	wire [OCC_W-1:0] occupancy = OCC_W'(back_level) + OCC_W'(done_q);

	// ----------------------------------------------------------------
	// read words of every mapped offset
	// ----------------------------------------------------------------
	wire [31:0] word_res  = {16'h0000, result_word};
	wire [31:0] word_sts  = flag_word(sts_q);
	wire [31:0] word_mask = flag_word(mask_q);
	wire [31:0] word_cfg  = {31'h00000000, diff_q};
	wire [31:0] word_lvl  = {{(32-OCC_W){1'b0}}, occupancy};

	wire [31:0] rd_mux =
		sel_res  ? word_res :
		sel_sts  ? word_sts :
		sel_mask ? word_mask :
		sel_cfg  ? word_cfg :
		sel_lvl  ? word_lvl :
		32'h00000000;

	// read data and the flags it carried are frozen one edge before the
	// completing edge; the pop then acts only on what software was shown
	wire [31:0] rdata_d = pwrite ? 32'h00000000 : rd_mux;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			rdata_q <= 32'h00000000;
		else if (capture)
			rdata_q <= rdata_d;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			err_q <= 1'b0;
		else if (capture)
			err_q <= ~mapped;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rd_done_q <= 1'b0;
			rd_oflw_q <= 1'b0;
		end
		else if (capture)
		begin
			rd_done_q <= done_q;
			rd_oflw_q <= oflw_q;
		end
	end

	// ----------------------------------------------------------------
	// queue behind the display register
	// ----------------------------------------------------------------
	// total capacity is the display entry plus the entries behind it
	wire queue_full = done_q & ~back_ready;
	wire push_in    = conv_valid & ~queue_full;
	wire dropped    = conv_valid & queue_full;
	wire popped     = rd_res & rd_done_q;

	// refill waits a clock after a pop so done is seen low once
	wire refill     = ~done_q & back_valid & ~popped;
	wire [ENT_W-1:0] push_entry = {conv_sign, conv_data};

	arf_fifo
	#(
		.WIDTH (ENT_W),
		.DEPTH (BACK)
	)
	arf_fifo_inst
	(
		.clk        (pclk),
		.rst_n      (presetn),
		.push_valid (push_in),
		.push_ready (back_ready),
		.push_data  (push_entry),
		.pop_valid  (back_valid),
		.pop_ready  (refill),
		.pop_data   (back_data),
		.level      (back_level)
	);

	// ----------------------------------------------------------------
	// display register
	// ----------------------------------------------------------------
	logic                      done_d;
	logic [RES_W-1:0]          res_d;
	logic                      sign_d;

	always_comb
	begin
		done_d = done_q;
		res_d  = res_q;
		sign_d = sign_q;
		if (refill)
		begin
			done_d = 1'b1;
			res_d  = back_data[RES_W-1:0];
			sign_d = back_data[RES_W];
		end
		else if (popped)
		begin
			done_d = 1'b0;
			res_d  = '0;
			sign_d = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			done_q <= 1'b0;
			res_q  <= '0;
			sign_q <= 1'b0;
		end
		else
		begin
			done_q <= done_d;
			res_q  <= res_d;
			sign_q <= sign_d;
		end
	end

	// ----------------------------------------------------------------
	// overflow flag
	// ----------------------------------------------------------------
	// a drop in the clearing cycle keeps the flag set
	wire oflw_clr = rd_res & rd_oflw_q;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			oflw_q <= 1'b0;
		else if (dropped)
			oflw_q <= 1'b1;
		else if (oflw_clr)
			oflw_q <= 1'b0;
	end

	// ----------------------------------------------------------------
	// software control registers
	// ----------------------------------------------------------------
	// writes to the result and level offsets fall through untouched
	wire wr_mask = wr_ok & sel_mask;
	wire wr_cfg  = wr_ok & sel_cfg;
	wire wr_sts  = wr_ok & sel_sts;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mask_q <= `ARF_MASK_RST;
			diff_q <= `ARF_CFG_RST;
		end
		else
		begin
			if (wr_mask)
				mask_q <= pwdata[`ARF_STS_W-1:0];
			if (wr_cfg)
				diff_q <= pwdata[`ARF_CFG_DIFF];
		end
	end

	// ----------------------------------------------------------------
	// sticky event status and interrupt
	// ----------------------------------------------------------------
	logic [`ARF_STS_W-1:0] evt;
	logic [`ARF_STS_W-1:0] clr;

	always_comb
	begin
		evt = '0;
		evt[`ARF_STS_READY]   = refill;
		evt[`ARF_STS_OVERRUN] = dropped;
	end

	assign clr = wr_sts ? pwdata[`ARF_STS_W-1:0] : '0;
	wire [`ARF_STS_W-1:0] sts_d = (sts_q & ~clr) | evt;

	// new events win over a write-one-to-clear in the same cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			sts_q <= `ARF_STS_RST;
		else
			sts_q <= sts_d;
	end

	wire [`ARF_STS_W-1:0] pending = sts_q & mask_q;
	assign irq = |pending;

endmodule

// [rtl/arf_cfg.svh]
// arf_cfg.svh: offsets, field positions, reset values and counts of the
// result queue readout. assumes inclusion by bare name, definitions only.
`ifndef ARF_CFG_SVH
`define ARF_CFG_SVH

// --------------------------------------------------------------------
// apb register byte offsets
// --------------------------------------------------------------------
`define ARF_OFS_RESULT   12'h000
`define ARF_OFS_STATUS   12'h004
`define ARF_OFS_MASK     12'h008
`define ARF_OFS_CONFIG   12'h00C
`define ARF_OFS_LEVEL    12'h010

// --------------------------------------------------------------------
// result register field positions
// --------------------------------------------------------------------
`define ARF_RES_MSB      11
`define ARF_BIT_SIGN     12
`define ARF_BIT_PEN      13
`define ARF_BIT_OFLW     14
`define ARF_BIT_DONE     15

// --------------------------------------------------------------------
// status / mask / config fields
// --------------------------------------------------------------------
`define ARF_STS_W        2
`define ARF_STS_READY    0
`define ARF_STS_OVERRUN  1
`define ARF_CFG_DIFF     0

// --------------------------------------------------------------------
// reset values and sizes
// --------------------------------------------------------------------
`define ARF_STS_RST      2'h0
`define ARF_MASK_RST     2'h0
`define ARF_CFG_RST      1'h0
`define ARF_QUEUE_DEPTH  4
`define ARF_RES_W        12
`define ARF_ADDR_W       12

`endif

// [rtl/arf_pkg.sv]
// arf_pkg.sv: types of the result queue readout.
// assumes arf_cfg.svh sits beside it.
package arf_pkg;

	// apb slave phase: capture read data, then answer
	typedef enum logic [1:0]
	{
		ARF_IDLE,
		ARF_CAPTURE,
		ARF_ANSWER
	} arf_apb_st_t;

endpackage

// [rtl/arf_fifo.sv]
// arf_fifo.sv: small queue with valid/ready on both sides.
// assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ps

module arf_fifo
	import arf_pkg::*;
#(
	parameter int WIDTH = 13,
	parameter int DEPTH = 3,
	parameter int LVL_W = $clog2(DEPTH + 1)
)
(
	input  wire logic               clk,
	input  wire logic               rst_n,
	input  wire logic               push_valid,
	output logic                    push_ready,
	input  wire logic [WIDTH-1:0]   push_data,
	output logic                    pop_valid,
	input  wire logic               pop_ready,
	output logic      [WIDTH-1:0]   pop_data,
	output logic      [LVL_W-1:0]   level
);

	localparam int IDX_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem [DEPTH];
	logic [IDX_W-1:0] wr_q;
	logic [IDX_W-1:0] rd_q;
	logic [LVL_W-1:0] cnt_q;

	// wrap an index at the queue depth
	function automatic logic [IDX_W-1:0] bump(input logic [IDX_W-1:0] idx);
		bump = (idx == IDX_W'(DEPTH - 1)) ? '0 : idx + IDX_W'(1);
	endfunction

	wire do_push = push_valid & push_ready;
	wire do_pop  = pop_valid & pop_ready;

	assign push_ready = (cnt_q != LVL_W'(DEPTH));
	assign pop_valid  = (cnt_q != '0);
	assign pop_data   = mem[rd_q];
	assign level      = cnt_q;

	always_ff @(posedge clk)
	begin
		if (do_push)
			mem[wr_q] <= push_data;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end
		else
		begin
			if (do_push)
				wr_q <= bump(wr_q);
			if (do_pop)
				rd_q <= bump(rd_q);
			if (do_push & ~do_pop)
				cnt_q <= cnt_q + LVL_W'(1);
			else if (do_pop & ~do_push)
				cnt_q <= cnt_q - LVL_W'(1);
		end
	end

endmodule

// [sim/arf_conv_model.sv]
// arf_conv_model.sv: converter core stand-in, one result per request cycle.
// assumes the bench raises req for each result it wants delivered.
`timescale 1ns/1ps

module arf_conv_model
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        req,
	input  wire logic [11:0] req_data,
	input  wire logic        req_sign,
	output logic             conv_valid,
	output logic      [11:0] conv_data,
	output logic             conv_sign
);
	// outside a result the value lines keep toggling, never a stale copy
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			conv_valid <= 1'b0;
			conv_data  <= 12'h000;
			conv_sign  <= 1'b0;
		end
		else
		begin
			conv_valid <= req;
			conv_data  <= req ? req_data : ~conv_data;
			conv_sign  <= req ? req_sign : ~conv_sign;
		end
	end
endmodule

// [sim/arf_top_checker.sv]
// arf_top_checker.sv: port-level assertions of the result queue readout.
// assumes arf_cfg.svh is on the include path; bound to arf_top below.
`timescale 1ns/1ps
`include "arf_cfg.svh"

module arf_top_checker
#(
	parameter int DEPTH = 4,
	parameter int RES_W = 12
)
(
	input wire logic                   pclk,
	input wire logic                   presetn,
	input wire logic                   psel,
	input wire logic                   penable,
	input wire logic                   pwrite,
	input wire logic [`ARF_ADDR_W-1:0] paddr,
	input wire logic [31:0]            prdata,
	input wire logic                   pready,
	input wire logic                   pslverr,
	input wire logic                   pen_down
);
	wire rd_res = pready && !pwrite && paddr == `ARF_OFS_RESULT;
	wire wr_res = pready && pwrite && paddr == `ARF_OFS_RESULT;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_answer;
		penable && !pready ##1 penable && pready;
	endsequence

	AST_ONE_WAIT: assert property (s_setup |=> s_answer)
		else $error("apb answer timing wrong");
	AST_READY_ONE: assert property (pready |=> !pready)
		else $error("pready held past one cycle");
	AST_READY_IN_XFER: assert property (pready |-> psel && penable)
		else $error("pready outside a transfer");
	AST_RES_HIGH_ZERO: assert property (rd_res |-> prdata[31:16] == 16'h0000)
		else $error("result upper half not zero");
	AST_NOT_DONE_ZERO: assert property (rd_res && !prdata[15] |-> prdata[12:0] == 13'h0000)
		else $error("value or sign set without done");
	AST_PEN_LIVE: assert property (rd_res && $stable(pen_down) |-> prdata[13] == pen_down)
		else $error("pen-down bit wrong");
	AST_WRITE_ZERO: assert property (pready && pwrite |-> prdata == 32'h00000000)
		else $error("write returned data");
	AST_RES_WRITE_OK: assert property (wr_res |-> !pslverr)
		else $error("result write flagged error");
endmodule

bind arf_top arf_top_checker #(.DEPTH(DEPTH), .RES_W(RES_W)) arf_top_checker_inst
(
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pen_down(pen_down)
);

// [sim/adc_result_fifo_readout_test.sv]
// adc_result_fifo_readout_test.sv: apb bench for the result queue readout.
// assumes arf_top, arf_conv_model and the checker are compiled first.
`timescale 1ns/1ps
`include "arf_cfg.svh"

module adc_result_fifo_readout_test;
	logic        pclk, presetn, psel, penable, pwrite, pen_down, held;
	logic [11:0] paddr, req_data, cd;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0]  pstrb;
	logic        pready, pslverr, irq, req, req_sign, cv, cs, er;
	int          errors, check_count;
	logic [15:0] exp_q [5] = '{16'hF001, 16'hA002, 16'hB003, 16'hA004, 16'h2000};

	initial
	begin
		pclk = 0;
		forever #25 pclk = ~pclk;
	end

	arf_top arf_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .conv_valid(cv), .conv_data(cd),
		.conv_sign(cs), .pen_down(pen_down), .irq(irq));
	arf_conv_model arf_conv_model_inst (.pclk(pclk), .presetn(presetn), .req(req),
		.req_data(req_data), .req_sign(req_sign), .conv_valid(cv), .conv_data(cd),
		.conv_sign(cs));

	// keep=1 leaves psel up so the next setup follows at once
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input bit keep);
		if (!held)
			@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		penable <= 0;
		held = keep;
		if (!keep)
			psel <= 0;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic push(input int n, input logic [11:0] v0, input logic s0);
		for (int i = 0; i < n; i++)
		begin
			@(posedge pclk);
			req <= 1;
			req_data <= v0 + i[11:0];
			req_sign <= s0 ^ i[0];
		end
		@(posedge pclk);
		req <= 0;
		repeat (4) @(posedge pclk);
	endtask

	task automatic tally_and_finish;
		if (errors == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	initial
	begin
		repeat (3000) @(posedge pclk);
		errors++;
		tally_and_finish;
	end

	initial
	begin
		{psel, penable, pwrite, paddr, pwdata, req, req_data, req_sign} = '0;
		pstrb = 4'hF;
		presetn = 0;
		pen_down = 1;
		held = 0;
		errors = 0;
		check_count = 0;
		repeat (12) @(posedge pclk);
		presetn <= 1;
		apb(0, `ARF_OFS_RESULT, 0, 0);
		chk(rd, 32'h2000);
		apb(0, `ARF_OFS_LEVEL, 0, 0);
		chk(rd, 32'h0);
		push(1, 12'hABC, 1);
		apb(0, `ARF_OFS_RESULT, 0, 0);
		chk(rd, 32'hAABC);
		apb(1, `ARF_OFS_CONFIG, 1, 0);
		push(5, 12'h001, 1);
		apb(0, `ARF_OFS_LEVEL, 0, 0);
		chk(rd, 32'h4);
		for (int i = 0; i < 5; i++)
		begin
			apb(0, `ARF_OFS_RESULT, 0, i < 4);
			chk(rd, {16'h0, exp_q[i]});
		end
		push(1, 12'h123, 0);
		apb(1, `ARF_OFS_RESULT, 32'hFFFF, 0);
		apb(0, `ARF_OFS_LEVEL, 0, 0);
		chk(rd, 32'h1);
		apb(0, `ARF_OFS_RESULT, 0, 0);
		chk(rd, 32'hA123);
		apb(0, `ARF_OFS_STATUS, 0, 0);
		chk(rd, 32'h3);
		chk(irq, 0);
		apb(1, `ARF_OFS_MASK, 3, 0);
		@(negedge pclk);
		chk(irq, 1);
		apb(1, `ARF_OFS_STATUS, 3, 0);
		@(negedge pclk);
		chk(irq, 0);
		apb(0, `ARF_OFS_STATUS, 0, 0);
		chk(rd, 32'h0);
		pstrb <= 4'hE;
		apb(1, `ARF_OFS_CONFIG, 0, 0);
		pstrb <= 4'hF;
		apb(0, `ARF_OFS_CONFIG, 0, 0);
		chk(rd, 32'h1);
		pen_down <= 0;
		push(1, 12'h055, 1);
		apb(0, `ARF_OFS_RESULT, 0, 0);
		chk(rd, 32'h9055);
		apb(0, `ARF_OFS_RESULT, 0, 0);
		chk(rd, 32'h0);
		pen_down <= 1;
		apb(0, `ARF_OFS_RESULT, 0, 0);
		chk(rd, 32'h2000);
		apb(0, 12'h014, 0, 0);
		chk(er, 1);
		tally_and_finish;
	end
endmodule
